// file: design/p0pm_top.sv
// Pin function multiplexer for port 0 pins 21-31 and port 1 pins 16-31
// Operation
// R1 - Pin 21: GPIO, PWM five, reserved, T1 capture3
// R2 - Pins 22 and 30 routed per select codes
// R3 - Pin 27: GPIO, analog 0, T0 cap1/match1
// R4 - Pin 28: GPIO, analog 1, T0 cap2/match2
// R5 - Pin 29: analog 2 etc; 29,30 reset 01
// R6 - Pin 23: GPIO or second CAN receive
// R7 - Pin 24: GPIO or second CAN transmit
// R8 - Pin 25: GPIO or first CAN receive
// R9 - Port1 bit 2 gives pins 31-26 debug
// R10 - Port1 bit 3 gives pins 25-16 trace
// R11 - Direction bit acts only in GPIO mode
// R12 - Peripheral functions set pin direction themselves
// R13 - Software never writes reserved codes or bits
// R14 - All GPIO pins are inputs after reset
// R15 - Pins 26 and 31 connect no function
// R16 - Select registers read back whole stored words
//
// Added by the designer: the Wishbone slave port.
module p0pm_top
	import p0pm_pkg::*;
(
	// Clock and reset
	input  wire logic             sys_clk_in,
	input  wire logic             rst_in,
	// Wishbone slave
	input  wire logic             wb_cyc_in,
	input  wire logic             wb_stb_in,
	input  wire logic             wb_we_in,
	input  wire logic [ADR_W-1:0] wb_adr_in,
	input  wire logic [3:0]       wb_sel_in,
	input  wire logic [DAT_W-1:0] wb_dat_in,
	output logic      [DAT_W-1:0] wb_dat_out,
	output logic                  wb_ack_out,
	// GPIO block side
	input  wire logic [31:21]     gpio0_data_in,
	output logic      [31:21]     gpio0_pins_out,
	input  wire logic [31:16]     gpio1_data_in,
	output logic      [31:16]     gpio1_pins_out,
	// Port 0 pads
	input  wire logic [31:21]     p0_pad_in,
	output logic      [31:21]     p0_pad_out,
	output logic      [31:21]     p0_pad_oe_out,
	// Port 1 pads
	input  wire logic [31:16]     p1_pad_in,
	output logic      [31:16]     p1_pad_out,
	output logic      [31:16]     p1_pad_oe_out,
	// Timer, PWM and interrupt side
	input  wire logic             pwm_output_five_in,
	input  wire logic [3:0]       t0_match_in,
	output logic      [3:0]       t0_capture_out,
	output logic                  t1_capture3_out,
	output logic                  external_interrupt_three_out,
	// CAN side
	input  wire logic             can_second_transmit_in,
	output logic                  can_second_receive_out,
	output logic                  can_first_receive_out,
	// Converter side
	output logic      [3:0]       analog_input_sel_out,
	// Debug and trace side
	input  wire logic [DBG_W-1:0] dbg_data_in,
	input  wire logic [DBG_W-1:0] dbg_oe_in,
	output logic      [DBG_W-1:0] dbg_pins_out,
	input  wire logic [TRC_W-1:0] trace_data_in
);

	// Byte-lane merge of a write into a stored word
	function automatic logic [31:0] p0pm_merge(
		input logic [31:0] old_w,
		input logic [31:0] new_w,
		input logic [3:0]  lanes
	);
		logic [31:0] res;
		res = old_w;
		for (int b = 0; b < 4; b++) begin
			if (lanes[b]) begin
				res[b*8 +: 8] = new_w[b*8 +: 8];
			end
		end
		return res;
	endfunction : p0pm_merge

	// Stored registers
	logic [31:0]      fsel_r;     // Port 0 high select word
	logic [1:0]       dtsel_r;    // Debug and trace selects
	logic [31:21]     dir0_r;     // Port 0 GPIO direction
	logic [31:16]     dir1_r;     // Port 1 GPIO direction
	logic             ack_r;      // Bus acknowledge
	logic [31:0]      rdat_r;     // Bus read data
	// Registered outputs and their next values
	logic [31:21]     p0_out_r, p0_out_nxt;
	logic [31:21]     p0_oe_r,  p0_oe_nxt;
	logic [31:16]     p1_out_r, p1_out_nxt;
	logic [31:16]     p1_oe_r,  p1_oe_nxt;
	logic [31:21]     p0_pin_r;   // Sampled port 0 pads
	logic [31:16]     p1_pin_r;   // Sampled port 1 pads
	logic [3:0]       t0cap_r, t0cap_nxt;
	logic             t1cap_r, t1cap_nxt;
	logic             eint_r,  eint_nxt;
	logic             can2rx_r, can2rx_nxt;
	logic             can1rx_r, can1rx_nxt;
	logic [3:0]       ain_r,   ain_nxt;
	logic [DBG_W-1:0] dbg_r,   dbg_nxt;

	// Bus decode
	wire        bus_req    = wb_cyc_in & wb_stb_in;
	wire        hit_fsel   = (wb_adr_in == ADR_P0_FSEL);
	wire        hit_dtsel  = (wb_adr_in == ADR_P1_DTSEL);
	wire        hit_dir0   = (wb_adr_in == ADR_P0_DIR);
	wire        hit_dir1   = (wb_adr_in == ADR_P1_DIR);
	wire        hit_pins0  = (wb_adr_in == ADR_P0_PINS);
	wire        hit_pins1  = (wb_adr_in == ADR_P1_PINS);
	wire        wr_commit  = bus_req & wb_we_in & ack_r;
	wire [31:0] wr_fsel    = p0pm_merge(fsel_r, wb_dat_in, wb_sel_in);
	wire [31:0] dt_word    = {28'h0000000, dtsel_r, 2'h0};
	wire [31:0] wr_dt      = p0pm_merge(dt_word, wb_dat_in, wb_sel_in);
	wire [31:0] dir0_word  = {dir0_r, 21'h000000};
	wire [31:0] wr_dir0    = p0pm_merge(dir0_word, wb_dat_in, wb_sel_in);
	wire [31:0] dir1_word  = {dir1_r, 16'h0000};
	wire [31:0] wr_dir1    = p0pm_merge(dir1_word, wb_dat_in, wb_sel_in);

	// Read mux; unmapped addresses read zero
	wire [31:0] rd_mux =
		hit_fsel  ? fsel_r :                        // R16
		hit_dtsel ? dt_word :                       // R16
		hit_dir0  ? dir0_word :
		hit_dir1  ? dir1_word :
		hit_pins0 ? {p0_pin_r, 21'h000000} :
		hit_pins1 ? {p1_pin_r, 16'h0000} :
		32'h00000000;

	// Select fields
	wire [1:0] sel21 = fsel_r[LSB_P21 +: 2];
	wire [1:0] sel22 = fsel_r[LSB_P22 +: 2];
	wire [1:0] sel23 = fsel_r[LSB_P23 +: 2];
	wire [1:0] sel24 = fsel_r[LSB_P24 +: 2];
	wire [1:0] sel25 = fsel_r[LSB_P25 +: 2];
	wire [1:0] sel27 = fsel_r[LSB_P27 +: 2];
	wire [1:0] sel28 = fsel_r[LSB_P28 +: 2];
	wire [1:0] sel29 = fsel_r[LSB_P29 +: 2];
	wire [1:0] sel30 = fsel_r[LSB_P30 +: 2];
	wire       dbg_en = dtsel_r[0];
	wire       trc_en = dtsel_r[1];

	// Bus acknowledge: one cycle, dropped the cycle after
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			ack_r  <= 1'b0;
			rdat_r <= 32'h00000000;
		end else begin
			ack_r  <= bus_req & ~ack_r;
			rdat_r <= rd_mux;
		end
	end

	// Select registers, written at the acknowledged edge
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			fsel_r  <= RST_P0_FSEL;             // R1 R3 R4 R5
			dtsel_r <= RST_P1_DT;               // R9 R10
		end else if (wr_commit && hit_fsel) begin
			fsel_r  <= wr_fsel;                 // R16
		end else if (wr_commit && hit_dtsel) begin
			dtsel_r <= wr_dt[BIT_TRACE:BIT_DEBUG]; // R13
		end
	end

	// Direction registers, all inputs after reset
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			dir0_r <= RST_DIR[31:21];           // R14
			dir1_r <= RST_DIR[31:16];           // R14
		end else if (wr_commit && hit_dir0) begin
			dir0_r <= wr_dir0[31:21];
		end else if (wr_commit && hit_dir1) begin
			dir1_r <= wr_dir1[31:16];
		end
	end

	// Port 0 pad drive
	always_comb begin
		p0_out_nxt = '0;
		p0_oe_nxt  = '0;
		// GPIO pins obey the direction bit only in GPIO mode
		for (int i = P0_LO; i < 32; i++) begin
			if (i != 26 && i != 31 &&
				fsel_r[(i-P0_FIELD_BASE)*2 +: 2] == SEL_GPIO) begin
				p0_out_nxt[i] = gpio0_data_in[i];
				p0_oe_nxt[i]  = dir0_r[i];          // R11
			end
		end
		// Pin 21 drives the PWM five output
		if (sel21 == SEL_FN1) begin
			p0_out_nxt[21] = pwm_output_five_in;
			p0_oe_nxt[21]  = 1'b1;                // R1 R12
		end
		// Pin 22 drives timer 0 match 0
		if (sel22 == SEL_FN3) begin
			p0_out_nxt[22] = t0_match_in[0];
			p0_oe_nxt[22]  = 1'b1;                // R2 R12
		end
		// Pin 24 drives the second CAN transmit line
		if (sel24 == SEL_FN1) begin
			p0_out_nxt[24] = can_second_transmit_in;
			p0_oe_nxt[24]  = 1'b1;                // R7 R12
		end
		// Pins 27 to 29 drive timer 0 matches 1 to 3
		if (sel27 == SEL_FN3) begin
			p0_out_nxt[27] = t0_match_in[1];
			p0_oe_nxt[27]  = 1'b1;                // R3 R12
		end
		if (sel28 == SEL_FN3) begin
			p0_out_nxt[28] = t0_match_in[2];
			p0_oe_nxt[28]  = 1'b1;                // R4 R12
		end
		if (sel29 == SEL_FN3) begin
			p0_out_nxt[29] = t0_match_in[3];
			p0_oe_nxt[29]  = 1'b1;                // R5 R12
		end
		// Pins 26 and 31 stay undriven in every code
		p0_oe_nxt[26] = 1'b0;                   // R15
		p0_oe_nxt[31] = 1'b0;                   // R15
	end

	// Peripheral inputs taken from port 0 pads
	always_comb begin
		// Timer 1 capture 3 from pin 21
		t1cap_nxt = (sel21 == SEL_FN3) & p0_pin_r[21];      // R1
		// Timer 0 capture 0 from pin 22 or pin 30
		t0cap_nxt[0] = ((sel22 == SEL_FN2) & p0_pin_r[22]) |
			((sel30 == SEL_FN3) & p0_pin_r[30]);           // R2
		t0cap_nxt[1] = (sel27 == SEL_FN2) & p0_pin_r[27];   // R3
		t0cap_nxt[2] = (sel28 == SEL_FN2) & p0_pin_r[28];   // R4
		t0cap_nxt[3] = (sel29 == SEL_FN2) & p0_pin_r[29];   // R5
		// External interrupt 3 from pin 30
		eint_nxt = (sel30 == SEL_FN2) & p0_pin_r[30];       // R2
		// CAN receive lines idle recessive when not routed
		can2rx_nxt = (sel23 == SEL_FN1) ? p0_pin_r[23] : 1'b1; // R6
		can1rx_nxt = (sel25 == SEL_FN1) ? p0_pin_r[25] : 1'b1; // R8
		// Analog channel hand-over flags
		ain_nxt[0] = (sel27 == SEL_FN1);                    // R3
		ain_nxt[1] = (sel28 == SEL_FN1);                    // R4
		ain_nxt[2] = (sel29 == SEL_FN1);                    // R5
		ain_nxt[3] = (sel30 == SEL_FN1);                    // R2
	end

	// Port 1 pad drive
	always_comb begin
		// GPIO default with software direction
		p1_out_nxt = gpio1_data_in;
		p1_oe_nxt  = dir1_r;                              // R11
		// Debug group takes pins 31 to 26
		if (dbg_en) begin
			p1_out_nxt[31:DBG_LO] = dbg_data_in;          // R9
			p1_oe_nxt[31:DBG_LO]  = dbg_oe_in;            // R9 R12
		end
		// Trace group takes pins 25 to 16, always driven
		if (trc_en) begin
			p1_out_nxt[DBG_LO-1:P1_LO] = trace_data_in;   // R10
			p1_oe_nxt[DBG_LO-1:P1_LO]  = '1;              // R10 R12
		end
		// Debug unit sees its pads only while selected
		dbg_nxt = dbg_en ? p1_pin_r[31:DBG_LO] : '0;      // R9
	end

	// Output and pad sampling registers
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			p0_out_r <= '0;
			p0_oe_r  <= '0;                       // R14
			p1_out_r <= '0;
			p1_oe_r  <= '0;                       // R14
			p0_pin_r <= '0;
			p1_pin_r <= '0;
		end else begin
			p0_out_r <= p0_out_nxt;
			p0_oe_r  <= p0_oe_nxt;
			p1_out_r <= p1_out_nxt;
			p1_oe_r  <= p1_oe_nxt;
			p0_pin_r <= p0_pad_in;
			p1_pin_r <= p1_pad_in;
		end
	end

	// Peripheral side registers
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			t0cap_r  <= '0;
			t1cap_r  <= 1'b0;
			eint_r   <= 1'b0;
			can2rx_r <= 1'b1;
			can1rx_r <= 1'b1;
			ain_r    <= '0;
			dbg_r    <= '0;
		end else begin
			t0cap_r  <= t0cap_nxt;
			t1cap_r  <= t1cap_nxt;
			eint_r   <= eint_nxt;
			can2rx_r <= can2rx_nxt;
			can1rx_r <= can1rx_nxt;
			ain_r    <= ain_nxt;
			dbg_r    <= dbg_nxt;
		end
	end

	// Output wiring, all from flip-flops
	assign wb_ack_out                   = ack_r;
	assign wb_dat_out                   = rdat_r;
	assign p0_pad_out                   = p0_out_r;
	assign p0_pad_oe_out                = p0_oe_r;
	assign p1_pad_out                   = p1_out_r;
	assign p1_pad_oe_out                = p1_oe_r;
	assign gpio0_pins_out               = p0_pin_r;
	assign gpio1_pins_out               = p1_pin_r;
	assign t0_capture_out               = t0cap_r;
	assign t1_capture3_out              = t1cap_r;
	assign external_interrupt_three_out = eint_r;
	assign can_second_receive_out       = can2rx_r;
	assign can_first_receive_out        = can1rx_r;
	assign analog_input_sel_out         = ain_r;
	assign dbg_pins_out                 = dbg_r;

endmodule : p0pm_top

// file: design/p0pm_pkg.sv
// Constants for the port 0 high and port 1 pin function multiplexer
package p0pm_pkg;

	// Bus widths
	localparam int ADR_W = 32;
	localparam int DAT_W = 32;

	// Register byte addresses
	localparam logic [31:0] ADR_P0_FSEL  = 32'he002c004;
	localparam logic [31:0] ADR_P1_DTSEL = 32'he002c014;
	localparam logic [31:0] ADR_P0_DIR   = 32'he002c020;
	localparam logic [31:0] ADR_P1_DIR   = 32'he002c024;
	localparam logic [31:0] ADR_P0_PINS  = 32'he002c028;
	localparam logic [31:0] ADR_P1_PINS  = 32'he002c02c;

	// Reset values
	localparam logic [31:0] RST_P0_FSEL = 32'h15400000;
	localparam logic [1:0]  RST_P1_DT   = 2'h0;
	localparam logic [31:0] RST_DIR     = 32'h00000000;

	// Select field codes
	localparam logic [1:0] SEL_GPIO = 2'h0;
	localparam logic [1:0] SEL_FN1  = 2'h1;
	localparam logic [1:0] SEL_FN2  = 2'h2;
	localparam logic [1:0] SEL_FN3  = 2'h3;

	// Field positions in the port 0 select word
	localparam int P0_FIELD_BASE = 16;
	localparam int LSB_P21 = 10;
	localparam int LSB_P22 = 12;
	localparam int LSB_P23 = 14;
	localparam int LSB_P24 = 16;
	localparam int LSB_P25 = 18;
	localparam int LSB_P27 = 22;
	localparam int LSB_P28 = 24;
	localparam int LSB_P29 = 26;
	localparam int LSB_P30 = 28;

	// Port 1 select bits and pin groups
	localparam int BIT_DEBUG = 2;
	localparam int BIT_TRACE = 3;
	localparam int P0_LO     = 21;
	localparam int P1_LO     = 16;
	localparam int DBG_LO    = 26;
	localparam int DBG_W     = 6;
	localparam int TRC_W     = 10;

endpackage : p0pm_pkg

// file: sim/p0pm_checker.sv
// Port-side assertions for the pin function multiplexer
module p0pm_checker
	import p0pm_pkg::*;
(
	// Clock and reset
	input wire logic             sys_clk_in,
	input wire logic             rst_in,
	// Bus
	input wire logic             wb_cyc_in,
	input wire logic             wb_stb_in,
	input wire logic             wb_we_in,
	input wire logic [ADR_W-1:0] wb_adr_in,
	input wire logic [3:0]       wb_sel_in,
	input wire logic [DAT_W-1:0] wb_dat_in,
	input wire logic             wb_ack_out,
	// Pads
	input wire logic [31:21]     p0_pad_in,
	input wire logic [31:21]     p0_pad_out,
	input wire logic [31:21]     p0_pad_oe_out,
	input wire logic [31:16]     p1_pad_out,
	input wire logic [31:16]     p1_pad_oe_out,
	// Peripherals
	input wire logic             pwm_output_five_in,
	input wire logic             can_second_transmit_in,
	input wire logic [3:0]       t0_capture_out,
	input wire logic             external_interrupt_three_out,
	input wire logic             can_first_receive_out,
	input wire logic [3:0]       analog_input_sel_out,
	input wire logic [DBG_W-1:0] dbg_data_in,
	input wire logic [DBG_W-1:0] dbg_oe_in,
	input wire logic [TRC_W-1:0] trace_data_in
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] fsel_r;  // Shadow of the port 0 select word
	logic [1:0]  dt_r;    // Shadow of debug and trace bits
	wire         wr = wb_cyc_in & wb_stb_in & wb_we_in & wb_ack_out;
	// Track select writes at the ack edge
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			fsel_r <= RST_P0_FSEL;
			dt_r <= RST_P1_DT;
		end else if (wr && wb_adr_in == ADR_P0_FSEL) begin
			for (int i = 0; i < 4; i++)
				if (wb_sel_in[i]) fsel_r[8*i +: 8] <= wb_dat_in[8*i +: 8];
		end else if (wr && wb_adr_in == ADR_P1_DTSEL && wb_sel_in[0]) begin
			dt_r <= wb_dat_in[3:2];
		end
	end
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (rst_in);
	sequence s_take;
		wb_cyc_in && wb_stb_in && !wb_ack_out;
	endsequence
	AST_ACK_ONE: assert property (s_take |=> wb_ack_out)
		else $error("ack missing after request");
	AST_ACK_PULSE: assert property (wb_ack_out |=> !wb_ack_out)
		else $error("ack held too long");
	AST_RST_INPUT: assert property ($fell(rst_in) |-> !(|p0_pad_oe_out) && !(|p1_pad_oe_out))
		else $error("pad driven after reset");
	AST_P21_PWM: assert property ($past(fsel_r[11:10]) == 2'h1 && !$past(rst_in) |->
		p0_pad_oe_out[21] && p0_pad_out[21] == $past(pwm_output_five_in))
		else $error("pin 21 not driven by pwm");
	AST_P24_TX: assert property ($past(fsel_r[17:16]) == 2'h1 && !$past(rst_in) |->
		p0_pad_oe_out[24] && p0_pad_out[24] == $past(can_second_transmit_in))
		else $error("pin 24 not driven by can transmit");
	AST_P27_AIN: assert property ($past(fsel_r[23:22]) == 2'h1 && !$past(rst_in) |->
		!p0_pad_oe_out[27] && analog_input_sel_out[0])
		else $error("pin 27 analog mode wrong");
	AST_P28_CAP: assert property ($past(fsel_r[25:24], 2) == 2'h2 && $past(fsel_r[25:24]) == 2'h2
		&& !$past(rst_in) && !$past(rst_in, 2) |-> t0_capture_out[2] == $past(p0_pad_in[28], 2))
		else $error("pin 28 capture wrong");
	AST_P30_EINT: assert property ($past(fsel_r[29:28], 2) == 2'h2 && $past(fsel_r[29:28]) == 2'h2
		&& !$past(rst_in) && !$past(rst_in, 2) |->
		external_interrupt_three_out == $past(p0_pad_in[30], 2))
		else $error("pin 30 interrupt wrong");
	AST_P25_IDLE: assert property ($past(fsel_r[19:18], 2) != 2'h1 && $past(fsel_r[19:18]) != 2'h1
		|-> can_first_receive_out)
		else $error("can receive not recessive");
	AST_NO_FN: assert property (!p0_pad_oe_out[26] && !p0_pad_oe_out[31])
		else $error("pin 26 or 31 driven");
	AST_DEBUG: assert property ($past(dt_r[0]) && !$past(rst_in) |->
		p1_pad_oe_out[31:26] == $past(dbg_oe_in) && p1_pad_out[31:26] == $past(dbg_data_in))
		else $error("debug pins wrong");
	AST_TRACE: assert property ($past(dt_r[1]) && !$past(rst_in) |->
		p1_pad_oe_out[25:16] == 10'h3ff && p1_pad_out[25:16] == $past(trace_data_in))
		else $error("trace pins wrong");
endmodule : p0pm_checker

bind p0pm_top p0pm_checker p0pm_checker_inst (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
	.wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
	.wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in), .wb_ack_out(wb_ack_out),
	.p0_pad_in(p0_pad_in), .p0_pad_out(p0_pad_out), .p0_pad_oe_out(p0_pad_oe_out),
	.p1_pad_out(p1_pad_out), .p1_pad_oe_out(p1_pad_oe_out),
	.pwm_output_five_in(pwm_output_five_in), .can_second_transmit_in(can_second_transmit_in),
	.t0_capture_out(t0_capture_out), .external_interrupt_three_out(external_interrupt_three_out),
	.can_first_receive_out(can_first_receive_out), .analog_input_sel_out(analog_input_sel_out),
	.dbg_data_in(dbg_data_in), .dbg_oe_in(dbg_oe_in), .trace_data_in(trace_data_in));

// file: sim/p0pm_tb_top.sv
// Self-checking bench for the pin function multiplexer
module p0pm_tb_top
	import p0pm_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        sys_clk_in = 1'b0;  // Bus clock
	logic        rst_in = 1'b1;      // Reset
	logic        wb_cyc = 1'b0;      // Bus request
	logic        wb_stb = 1'b0;
	logic        wb_we = 1'b0;
	logic [31:0] wb_adr = 32'h0;
	logic [3:0]  wb_sel = 4'h0;
	logic [31:0] wb_dat = 32'h0;
	logic [31:0] wb_dat_out;
	logic        wb_ack_out;
	logic [95:0] rnd = 96'h0;        // Random pad and peripheral levels
	logic [31:21] p0_oe;
	logic [31:0] q;
	logic [31:0] w;
	logic [31:0] dtw;                // Debug and trace word written
	logic [31:0] d1w;                // Port 1 direction word written
	logic        hold = 1'b0;        // Freezes the random levels
	logic [31:21] p0_out;            // Port 0 pad drive
	logic [31:16] p1_out;            // Port 1 pad drive
	logic [31:16] p1_oe;             // Port 1 pad enable
	logic [31:21] g0;                // Port 0 pad levels to GPIO
	logic [31:16] g1;                // Port 1 pad levels to GPIO
	logic [3:0]  t0c;                // Timer 0 captures
	logic        t1c;                // Timer 1 capture 3
	logic        eint;               // External interrupt three
	logic        can2;               // Second CAN receive
	logic        can1;               // First CAN receive
	logic [3:0]  ain;                // Analog channel flags
	logic [5:0]  dbg;                // Debug pad levels
	int          errors = 0;
	int          n_compared = 0;
	// Clock
	always #12.5 sys_clk_in = ~sys_clk_in;
	// Fresh random input levels every cycle unless held
	always @(posedge sys_clk_in) begin
		if (!hold) begin
			rnd <= {$urandom, $urandom, $urandom};
		end
	end
	p0pm_top p0pm_top_inst (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .wb_cyc_in(wb_cyc),
		.wb_stb_in(wb_stb), .wb_we_in(wb_we), .wb_adr_in(wb_adr), .wb_sel_in(wb_sel),
		.wb_dat_in(wb_dat), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
		.gpio0_data_in(rnd[10:0]), .gpio0_pins_out(g0), .gpio1_data_in(rnd[26:11]),
		.gpio1_pins_out(g1), .p0_pad_in(rnd[37:27]), .p0_pad_out(p0_out), .p0_pad_oe_out(p0_oe),
		.p1_pad_in(rnd[53:38]), .p1_pad_out(p1_out), .p1_pad_oe_out(p1_oe),
		.pwm_output_five_in(rnd[54]), .t0_match_in(rnd[58:55]), .t0_capture_out(t0c),
		.t1_capture3_out(t1c), .external_interrupt_three_out(eint),
		.can_second_transmit_in(rnd[59]), .can_second_receive_out(can2),
		.can_first_receive_out(can1), .analog_input_sel_out(ain),
		.dbg_data_in(rnd[65:60]), .dbg_oe_in(rnd[71:66]), .dbg_pins_out(dbg),
		.trace_data_in(rnd[81:72]));
	// Verdict and end of run
	task automatic end_of_test();
		$display("errors %0d compared %0d", errors, n_compared);
		if (errors == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : end_of_test
	// Compare one value
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	// One classic bus cycle, held until ack
	task automatic wb(input logic we, input logic [31:0] a, input logic [3:0] s,
		input logic [31:0] d, output logic [31:0] rd);
		int n;
		@(posedge sys_clk_in);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= a;
		wb_sel <= s;
		wb_dat <= d;
		n = 0;
		// Ack and read data are taken at the rising edge itself
		do begin
			@(posedge sys_clk_in);
			n++;
		end while (wb_ack_out !== 1'b1 && n < 20);
		if (wb_ack_out !== 1'b1) begin
			errors++;
			end_of_test();
		end
		rd = wb_dat_out;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
	endtask : wb
	// Random select word with no reserved codes
	function automatic logic [31:0] legal(input logic [31:0] r);
		logic [31:0] v;
		v = r & 32'h3fc57fff;
		if (v[11:10] == 2'h2) v[11:10] = 2'h3;
		if (v[13:12] == 2'h1) v[13:12] = 2'h0;
		return v;
	endfunction : legal
	// Expected port 0 {enable, drive} for a select word and directions
	function automatic logic [21:0] p0_exp(input logic [31:0] s, input logic [10:0] d,
		input logic [95:0] r);
		logic [10:0] o;
		logic [10:0] e;
		logic [1:0]  c;
		o = 11'h000;
		e = 11'h000;
		// General I/O pins follow data and direction
		for (int p = 0; p < 10; p++) begin
			c = s[10 + 2*p +: 2];
			if (p != 5 && c == 2'h0) begin
				o[p] = r[p];
				e[p] = d[p];
			end
		end
		// Peripheral outputs drive their pins
		if (s[11:10] == 2'h1) begin
			o[0] = r[54];
			e[0] = 1'b1;
		end
		if (s[13:12] == 2'h3) begin
			o[1] = r[55];
			e[1] = 1'b1;
		end
		if (s[17:16] == 2'h1) begin
			o[3] = r[59];
			e[3] = 1'b1;
		end
		if (s[23:22] == 2'h3) begin
			o[6] = r[56];
			e[6] = 1'b1;
		end
		if (s[25:24] == 2'h3) begin
			o[7] = r[57];
			e[7] = 1'b1;
		end
		if (s[27:26] == 2'h3) begin
			o[8] = r[58];
			e[8] = 1'b1;
		end
		return {e, o};
	endfunction : p0_exp
	// Expected port 1 {enable, drive} for debug and trace selects
	function automatic logic [31:0] p1_exp(input logic [1:0] t, input logic [15:0] d,
		input logic [95:0] r);
		logic [15:0] o;
		logic [15:0] e;
		o = r[26:11];
		e = d;
		if (t[0]) begin
			o[15:10] = r[65:60];
			e[15:10] = r[71:66];
		end
		if (t[1]) begin
			o[9:0] = r[81:72];
			e[9:0] = 10'h3ff;
		end
		return {e, o};
	endfunction : p1_exp
	// Expected {interrupt, timer 1 capture, timer 0 captures} from pad levels
	function automatic logic [5:0] cap_exp(input logic [31:0] s, input logic [95:0] r);
		logic [3:0] c;
		c[0] = ((s[13:12] == 2'h2) & r[28]) | ((s[29:28] == 2'h3) & r[36]);
		c[1] = (s[23:22] == 2'h2) & r[33];
		c[2] = (s[25:24] == 2'h2) & r[34];
		c[3] = (s[27:26] == 2'h2) & r[35];
		return {(s[29:28] == 2'h2) & r[36], (s[11:10] == 2'h3) & r[27], c};
	endfunction : cap_exp
	// Freeze the levels, let them settle, compare every routed output
	task automatic check_pins(input logic [31:0] s, input logic [1:0] t,
		input logic [10:0] d0, input logic [15:0] d1);
		@(posedge sys_clk_in);
		hold <= 1'b1;
		repeat (4) @(negedge sys_clk_in);
		chk("port0 drive", {10'h000, p0_oe, p0_out}, {10'h000, p0_exp(s, d0, rnd)});
		chk("port1 drive", {p1_oe, p1_out}, p1_exp(t, d1, rnd));
		chk("pad levels", {5'h00, g0, g1}, {5'h00, rnd[37:27], rnd[53:38]});
		chk("captures", {26'h0000000, eint, t1c, t0c}, {26'h0000000, cap_exp(s, rnd)});
		chk("can receive", {30'h00000000, can2, can1},
			{30'h00000000, (s[15:14] == 2'h1) ? rnd[29] : 1'b1,
			(s[19:18] == 2'h1) ? rnd[31] : 1'b1});
		chk("analog select", {28'h0000000, ain}, {28'h0000000, (s[29:28] == 2'h1),
			(s[27:26] == 2'h1), (s[25:24] == 2'h1), (s[23:22] == 2'h1)});
		chk("debug pads", {26'h0000000, dbg},
			{26'h0000000, t[0] ? rnd[53:48] : 6'h00});
		@(posedge sys_clk_in);
		hold <= 1'b0;
	endtask : check_pins
	// Main sequence
	initial begin
		void'($urandom(87625));
		repeat (12) @(posedge sys_clk_in);
		rst_in <= 1'b0;
		repeat (3) @(negedge sys_clk_in);
		chk("oe after reset", {21'h0, p0_oe}, 32'h0);
		wb(1'b0, ADR_P0_FSEL, 4'hf, 32'h0, q);
		chk("select reset", q, 32'h15400000);
		wb(1'b0, ADR_P1_DTSEL, 4'hf, 32'h0, q);
		chk("debug reset", q, 32'h0);
		check_pins(RST_P0_FSEL, RST_P1_DT, 11'h000, 16'h0000);
		wb(1'b0, 32'he002c008, 4'hf, 32'h0, q);
		chk("unmapped", q, 32'h0);
		wb(1'b1, ADR_P0_DIR, 4'hf, 32'hffe00000, q);
		repeat (2) @(negedge sys_clk_in);
		chk("oe gpio out", {21'h0, p0_oe}, 32'h1f);
		wb(1'b1, ADR_P0_FSEL, 4'h4, 32'hffc1ffff, q);
		wb(1'b0, ADR_P0_FSEL, 4'hf, 32'h0, q);
		chk("lane write", q, 32'h15c10000);
		repeat (2) @(negedge sys_clk_in);
		chk("oe peripheral", {21'h0, p0_oe}, 32'h5f);
		wb(1'b1, ADR_P1_DTSEL, 4'hf, 32'hc, q);
		wb(1'b0, ADR_P1_DTSEL, 4'hf, 32'h0, q);
		chk("debug trace", q, 32'hc);
		for (int i = 0; i < 24; i++) begin
			w = legal($urandom);
			wb(1'b1, ADR_P0_FSEL, 4'hf, w, q);
			wb(1'b0, ADR_P0_FSEL, 4'hf, 32'h0, q);
			chk("select word", q, w);
			dtw = $urandom & 32'hc;
			wb(1'b1, ADR_P1_DTSEL, 4'hf, dtw, q);
			d1w = $urandom & 32'hffff0000;
			wb(1'b1, ADR_P1_DIR, 4'hf, d1w, q);
			check_pins(w, dtw[3:2], 11'h7ff, d1w[31:16]);
		end
		end_of_test();
	end
endmodule : p0pm_tb_top
